// File: rtl/sacs_map.vh
`ifndef SACS_MAP_VH
`define SACS_MAP_VH
// =====================================================
// Result word
`define SACS_RES_W       18
`define SACS_RES_MSB     17
`define SACS_FULL_SCALE  18'h3FFFF
`define SACS_HALF_SCALE  18'h20000
`define SACS_RES_RST     18'h00000
// =====================================================
// Timing (clock 50 MHz, period 20 ns)
`define SACS_CLK_PERIOD_NS  20
`define SACS_CONV_MAX_NS    3000
`define SACS_STRB_WIN_NS    40
// Cycles per approximation step, rounded down so 18 steps fit in the longest time
`define SACS_STEP_CYC  ((`SACS_CONV_MAX_NS / `SACS_CLK_PERIOD_NS) / `SACS_RES_W)
`define SACS_STEP_W    4
`define SACS_BIT_W     5
`endif

// File: rtl/sacs_buf2.v
`include "sacs_map.vh"
module sacs_buf2 (
  input  wire                      i_sys_clk,
  input  wire                      i_rst_n,
  input  wire                      i_in_valid,
  output wire                      o_in_ready,
  input  wire [`SACS_RES_MSB:0]    i_in_data,
  output wire                      o_out_valid,
  input  wire                      i_out_ready,
  output wire [`SACS_RES_MSB:0]    o_out_data
);
  // =====================================================
  // Two-entry buffer
  reg [`SACS_RES_MSB:0] mem_reg [0:1];
  reg                   wr_ptr_reg;
  reg                   rd_ptr_reg;
  reg [1:0]             count_reg;
  wire                  push;
  wire                  pop;

  assign o_in_ready  = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= `SACS_RES_RST;
      mem_reg[1] <= `SACS_RES_RST;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 2'h1;
        2'b01:   count_reg <= count_reg - 2'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule // sacs_buf2

// File: rtl/sacs_core.v
// Functional notes
// - With the chain select low, the shared pin is an active-low enable for the serial output.
// - With the chain select high, the shared pin is the serial input from an upstream converter.
// - While enabled, each rising serial clock edge shifts out own result bits, then chained-in data (zeros with chain select low).
// - The serial output advances on each enabled rising serial clock edge, most significant bit first.
// - A rising strobe edge powers up the converter and starts a new conversion.
// - Busy rises when a conversion starts and falls when it finishes.
// - The converter alternates between acquisition and conversion, entered on a strobe rise.
// - Conversion runs 18 approximation steps from half scale, halving the weight each step.
// - At the end of conversion the 18-bit result enters a two-entry buffer that loads the serial shift path once the previous word is out.
// - The result is straight binary: zero input is all zeros, full scale is all ones.
// - Strobe edges during a running conversion do not restart it.
// - An internal time base finishes each conversion within 3 us of its start.
// - After conversion the converter powers down and the last result can still be read.
// - The result msb stays on the output until the first rising serial clock edge.
`include "sacs_map.vh"
module sacs_core (
  input  wire                      i_sys_clk,
  input  wire                      i_rst_n,
  input  wire                      i_conversion_strobe,
  input  wire                      i_chain_sel,
  input  wire                      i_out_enable_or_chain_in,
  input  wire                      i_serial_clk,
  input  wire                      i_cmp_above,
  output wire [`SACS_RES_MSB:0]    o_capacitive_dac,
  output wire                      o_sampling,
  output wire                      o_powered,
  output wire                      o_busy,
  output wire                      o_sdata,
  output wire                      o_sdata_oe,
  output wire                      o_sdata_valid,
  output reg                       o_overrun
);
  // =====================================================
  // States
  localparam ST_ACQ  = 1'b0;
  localparam ST_CONV = 1'b1;

  // =====================================================
  // Input synchronisers
  // Strobe, chain select, shared pin and serial clock pass two flops before use; the enable resets high so the
  // output starts released and no false enable follows reset.
  // Serial clock and strobe edges are seen three system clocks after the pin.

  reg [1:0] strb_sync_reg;
  reg [1:0] chain_sync_reg;
  reg [1:0] oe_sync_reg;
  reg [1:0] sclk_sync_reg;
  reg       strb_prev_reg;
  reg       sclk_prev_reg;
  wire      chain_mode;
  wire      shared_in;
  wire      strb_rise;
  wire      sclk_rise;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      strb_sync_reg  <= 2'h0;
      chain_sync_reg <= 2'h0;
      oe_sync_reg    <= 2'h3;
      sclk_sync_reg  <= 2'h0;
      strb_prev_reg  <= 1'b0;
      sclk_prev_reg  <= 1'b0;
    end else begin
      strb_sync_reg  <= {strb_sync_reg[0], i_conversion_strobe};
      chain_sync_reg <= {chain_sync_reg[0], i_chain_sel};
      oe_sync_reg    <= {oe_sync_reg[0], i_out_enable_or_chain_in};
      sclk_sync_reg  <= {sclk_sync_reg[0], i_serial_clk};
      strb_prev_reg  <= strb_sync_reg[1];
      sclk_prev_reg  <= sclk_sync_reg[1];
    end
  end

  assign chain_mode = chain_sync_reg[1];
  assign shared_in  = oe_sync_reg[1];
  assign strb_rise  = strb_sync_reg[1] & ~strb_prev_reg;
  assign sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;

  // =====================================================
  // Conversion sequencer
  reg                     state_reg;
  reg [`SACS_STEP_W-1:0]  step_cnt_reg;
  reg [`SACS_BIT_W-1:0]   bit_idx_reg;
  reg [`SACS_RES_MSB:0]   trial_reg;
  reg [`SACS_RES_MSB:0]   weight_reg;
  reg                     done_reg;
  wire                    step_tick;
  wire [`SACS_RES_MSB:0]  keep_trial;
  wire [`SACS_RES_MSB:0]  final_code;

  // Step divider stands in for the internal oscillator
  // 18 steps of 8 cycles give 2.88 us, leaving margin under the 3 us ceiling
  assign step_tick  = (state_reg == ST_CONV) &&
                      (step_cnt_reg == (`SACS_STEP_CYC - 1));
  // Straight binary: a set bit means the input lies above that weight
  assign keep_trial = i_cmp_above ? trial_reg : (trial_reg & ~weight_reg);
  assign final_code = keep_trial;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg    <= ST_ACQ;
      step_cnt_reg <= {`SACS_STEP_W{1'b0}};
      bit_idx_reg  <= {`SACS_BIT_W{1'b0}};
      trial_reg    <= `SACS_RES_RST;
      weight_reg   <= `SACS_RES_RST;
      done_reg     <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_ACQ: begin
          if (strb_rise) begin
            state_reg    <= ST_CONV;
            step_cnt_reg <= {`SACS_STEP_W{1'b0}};
            bit_idx_reg  <= {`SACS_BIT_W{1'b0}};
            trial_reg    <= `SACS_HALF_SCALE;
            weight_reg   <= `SACS_HALF_SCALE;
          end
        end
        ST_CONV: begin
          // Strobe edges are ignored here so a running conversion cannot restart
          if (step_tick) begin
            step_cnt_reg <= {`SACS_STEP_W{1'b0}};
            if (bit_idx_reg == (`SACS_RES_W - 1)) begin
              trial_reg <= final_code;
              state_reg <= ST_ACQ;
              done_reg  <= 1'b1;
            end else begin
              trial_reg   <= keep_trial | (weight_reg >> 1);
              weight_reg  <= weight_reg >> 1;
              bit_idx_reg <= bit_idx_reg + 1'b1;
            end
          end else begin
            step_cnt_reg <= step_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= ST_ACQ;
      endcase
    end
  end

  // =====================================================
  // Status outputs
  // Powered and busy share the state bit: power is only spent while converting,
  // and the last result stays readable while powered down.
  assign o_capacitive_dac = trial_reg;
  assign o_sampling       = (state_reg == ST_ACQ);
  assign o_powered        = (state_reg == ST_CONV);
  assign o_busy           = (state_reg == ST_CONV);

  // =====================================================
  // Result buffer: holds words when the shifter is still busy
  wire                   buf_in_ready;
  wire                   buf_out_valid;
  wire [`SACS_RES_MSB:0] buf_out_data;
  reg                    shift_load;

  sacs_buf2 u_buf (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (done_reg),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (trial_reg),
    .o_out_valid (buf_out_valid),
    .i_out_ready (shift_load),
    .o_out_data  (buf_out_data)
  );

  // A word arriving with the buffer full is dropped and flagged
  // Set wins over the clear when both fall in one cycle
  always @(posedge i_sys_clk) begin
    if (!i_rst_n)
      o_overrun <= 1'b0;
    else if (done_reg && !buf_in_ready)
      o_overrun <= 1'b1;
    else if (strb_rise)
      o_overrun <= 1'b0;
  end

  // =====================================================
  // Serial shift path
  reg [`SACS_RES_MSB:0]  shift_reg;
  reg [`SACS_BIT_W-1:0]  shifted_reg;
  reg                    word_valid_reg;
  wire                   out_en;

  // Load a new word only once the previous one has been fully clocked out
  // A load and a serial clock rise in one cycle: the load wins and the rise is
  // lost, so hosts must leave the clock low while a new word arrives.
  always @* begin
    shift_load = buf_out_valid &&
                 (!word_valid_reg || (shifted_reg >= `SACS_RES_W));
  end

  assign out_en = chain_mode | ~shared_in;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      shift_reg      <= `SACS_RES_RST;
      shifted_reg    <= {`SACS_BIT_W{1'b0}};
      word_valid_reg <= 1'b0;
    end else if (shift_load) begin
      shift_reg      <= buf_out_data;
      shifted_reg    <= {`SACS_BIT_W{1'b0}};
      word_valid_reg <= 1'b1;
    end else if (sclk_rise && out_en) begin
      // Chain mode feeds upstream data in behind our own bits
      shift_reg <= {shift_reg[`SACS_RES_MSB-1:0],
                    chain_mode ? shared_in : 1'b0};
      if (shifted_reg < `SACS_RES_W)
        shifted_reg <= shifted_reg + 1'b1;
    end
  end

  // =====================================================
  // Serial pins
  // The data bit always carries the shifter msb; the enable alone decides
  // whether the pad drives it, so a disabled host still sees a stable level.
  assign o_sdata       = shift_reg[`SACS_RES_MSB];
  assign o_sdata_oe    = out_en;
  assign o_sdata_valid = word_valid_reg;
endmodule // sacs_core

// File: verif/sacs_core_sva.sv
`include "sacs_map.vh"
module sacs_core_sva (
  input wire                   i_sys_clk,
  input wire                   i_rst_n,
  input wire                   i_conversion_strobe,
  input wire                   i_chain_sel,
  input wire                   i_out_enable_or_chain_in,
  input wire [`SACS_RES_MSB:0] o_capacitive_dac,
  input wire                   o_sampling,
  input wire                   o_powered,
  input wire                   o_busy,
  input wire                   o_sdata_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // Busy length counter and bits newly set in the trial code
  reg  [7:0]              bcnt_reg;
  reg  [`SACS_RES_MSB:0]  dac_reg;
  wire [`SACS_RES_MSB:0]  set_bits = o_capacitive_dac & ~dac_reg;
  always @(posedge i_sys_clk) begin
    bcnt_reg <= o_busy ? bcnt_reg + 8'h01 : 8'h00;
    dac_reg  <= o_capacitive_dac;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_BUSY_LEN: assert property ($fell(o_busy) |-> bcnt_reg == 8'h90)
    else $error("busy length wrong");
  AST_CONV_MAX: assert property (o_busy |-> bcnt_reg < 8'h96)
    else $error("conversion too long");
  AST_DAC_HALF: assert property ($rose(o_busy) |-> o_capacitive_dac == `SACS_HALF_SCALE)
    else $error("trial code not half scale");
  AST_SAR_STEP: assert property (o_busy && $past(o_busy) |-> (set_bits & (set_bits - 18'h00001)) == 18'h00000)
    else $error("more than one trial bit set");
  AST_PHASE: assert property (o_busy |-> o_powered && !o_sampling)
    else $error("phase wrong during conversion");
  AST_PDOWN: assert property ($fell(o_busy) |-> ##2 !o_powered && o_sampling)
    else $error("no power down after conversion");
  AST_NO_RESTART: assert property (o_busy && bcnt_reg > 8'h10 |-> o_capacitive_dac != `SACS_HALF_SCALE)
    else $error("conversion restarted");
  AST_STRB: assert property ($rose(i_conversion_strobe) && o_sampling |-> ##[3:5] $rose(o_busy))
    else $error("strobe did not start conversion");
  // Synchronisers need the pins quiet for a few cycles before the enable is judged
  AST_OE: assert property (($stable(i_chain_sel) && $stable(i_out_enable_or_chain_in))[*4]
    |-> o_sdata_oe == (i_chain_sel | ~i_out_enable_or_chain_in))
    else $error("output enable wrong");
  cover property ($fell(o_busy));
  cover property (i_chain_sel && o_sdata_oe);
  cover property (!i_chain_sel && !o_sdata_oe && !o_busy);
endmodule // sacs_core_sva
bind sacs_core sacs_core_sva i_sacs_core_sva (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_conversion_strobe(i_conversion_strobe),
  .i_chain_sel(i_chain_sel), .i_out_enable_or_chain_in(i_out_enable_or_chain_in),
  .o_capacitive_dac(o_capacitive_dac), .o_sampling(o_sampling), .o_powered(o_powered),
  .o_busy(o_busy), .o_sdata_oe(o_sdata_oe));

// File: verif/sacs_host.sv
module sacs_host (
  input  wire  i_sys_clk,
  input  wire  i_busy,
  input  wire  i_sdata,
  output logic o_strobe,
  output logic o_serial_clk,
  output logic o_en_or_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_strobe = 1'b0;
    o_serial_clk = 1'b0;
    o_en_or_sdi = 1'b1;
  end
  task automatic convert;
    int k;
    for (k = 0; k < 300 && i_busy; k++) @(posedge i_sys_clk);
    // One 20 ns high pulse: the falling edge stays inside the quiet window after the start
    @(posedge i_sys_clk) o_strobe <= 1'b1;
    @(posedge i_sys_clk) o_strobe <= 1'b0;
    for (k = 0; k < 300 && (i_busy || k < 10); k++) @(posedge i_sys_clk);
    repeat (6) @(posedge i_sys_clk);
  endtask
  // ====
  // Serial clock stands low between frames; mode 0 normal, 1 chain, 2 disabled
  task automatic read(input int n, input logic [35:0] s, input int m, output logic [35:0] w);
    w = 36'h000000000;
    @(posedge i_sys_clk) o_en_or_sdi <= m != 0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_sys_clk) o_serial_clk <= 1'b0;
      if (m == 1) o_en_or_sdi <= s[35 - i];
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk) w = {w[34:0], i_sdata};
      @(posedge i_sys_clk) o_serial_clk <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
    end
    @(posedge i_sys_clk) o_serial_clk <= 1'b0;
    // A released chain input must not keep its last bit
    o_en_or_sdi <= m == 1 ? ~o_en_or_sdi : 1'b1;
  endtask
endmodule // sacs_host

// File: verif/tb.sv
`include "sacs_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_sys_clk;
  logic                  i_rst_n;
  logic                  i_chain_sel;
  logic [`SACS_RES_MSB:0] vin;
  logic [`SACS_RES_MSB:0] v [0:3];
  logic [31:0]           rnd;
  logic [35:0]           w;
  wire  [`SACS_RES_MSB:0] dac;
  wire strobe, sclk, en_sdi, busy, sdata, sampling, sdata_valid, overrun;
  wire sdata_oe, sdata_pin;
  // A released output shows the inverse, so a host sampling it then reads wrong bits
  assign sdata_pin = sdata_oe ? sdata : ~sdata;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  sacs_core i_sacs_core (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_conversion_strobe(strobe),
    .i_chain_sel(i_chain_sel), .i_out_enable_or_chain_in(en_sdi), .i_serial_clk(sclk),
    .i_cmp_above(vin >= dac), .o_capacitive_dac(dac), .o_sampling(sampling), .o_powered(),
    .o_busy(busy), .o_sdata(sdata), .o_sdata_oe(sdata_oe), .o_sdata_valid(sdata_valid),
    .o_overrun(overrun));
  sacs_host i_sacs_host (.i_sys_clk(i_sys_clk), .i_busy(busy), .i_sdata(sdata_pin),
    .o_strobe(strobe), .o_serial_clk(sclk), .o_en_or_sdi(en_sdi));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  function automatic logic [17:0] sar_exp(input logic [17:0] a);
    logic [17:0] r;
    r = 18'h00000;
    for (int k = 17; k >= 0; k--) if (a >= (r | (18'h00001 << k))) r = r | (18'h00001 << k);
    return r;
  endfunction
  task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic conv(input logic [17:0] a);
    @(posedge i_sys_clk) vin <= a;
    i_sacs_host.convert;
  endtask
  task automatic rd(input logic [17:0] a);
    i_sacs_host.read(18, 36'h000000000, 0, w);
    chk("word", w[17:0], sar_exp(a));
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Ceiling is several times the expected run of about 4000 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim;
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_chain_sel = 1'b0;
    vin = 18'h00000;
    rnd = 32'h98D663B3;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    chk("busy", busy, 1'b0);
    chk("sampling", sampling, 1'b1);
    for (int t = 0; t < 6; t++) begin
      rnd = lfsr(rnd);
      v[0] = t == 0 ? 18'h00000 : t == 1 ? `SACS_FULL_SCALE : rnd[17:0];
      conv(v[0]);
      chk("valid", sdata_valid, 1'b1);
      rd(v[0]);
    end
    $display("test single words done");
    conv(v[0]);
    i_sacs_host.read(5, 36'h000000000, 2, w);
    chk("oe", sdata_oe, 1'b0);
    rd(v[0]);
    $display("test disabled clocks done");
    for (int j = 0; j < 4; j++) begin
      rnd = lfsr(rnd);
      v[j] = rnd[17:0];
      conv(v[j]);
      chk("overrun", overrun, j == 3);
    end
    for (int j = 0; j < 3; j++) rd(v[j]);
    conv(v[0]);
    chk("overrun", overrun, 1'b0);
    rd(v[0]);
    $display("test buffer full done");
    i_chain_sel <= 1'b1;
    conv(v[1]);
    rnd = lfsr(rnd);
    i_sacs_host.read(36, {rnd, rnd[3:0]}, 1, w);
    chk("chain", w, {sar_exp(v[1]), rnd[31:14]});
    chk("oe", sdata_oe, 1'b1);
    $display("test chain done");
    end_sim;
  end
endmodule // tb
